// >>> src/fbia_regs.svh
`ifndef FBIA_REGS_SVH
`define FBIA_REGS_SVH
// channel count and register map, per channel: index = {channel, sub}
`define FBIA_NUM_CH 8
`define FBIA_CH_W 3
`define FBIA_ADDR_W 8
// byte address = {channel[3:0], sub[3:0]} with sub as below
`define FBIA_OFS_STATUS 4'h0
`define FBIA_OFS_ENABLE 4'h1
`define FBIA_OFS_ALIAS 4'h2
`define FBIA_OFS_CTRL 4'h3
`define FBIA_OFS_LINK_SRC 4'h6
`define FBIA_OFS_SLIP_SRC 4'h9
`define FBIA_OFS_ALARM_SRC 4'h4
// field positions in status and enable
`define FBIA_BIT_SPARE 7
`define FBIA_BIT_LOOP 6
`define FBIA_BIT_CLKLOSS 5
`define FBIA_BIT_ONE_SECOND_TICK_FLAG 4
`define FBIA_BIT_LINK 3
`define FBIA_BIT_SLIP 2
`define FBIA_BIT_ALARM 1
`define FBIA_BIT_FRAME 0
// control register fields
`define FBIA_CTRL_IRQ_EN 0
`define FBIA_CTRL_AUTOCLR 1
`define FBIA_CTRL_WC 2
`define FBIA_RST_BYTE 8'h00
`endif

// >>> src/fbia_pkg.sv
package fbia_pkg;
  typedef logic [7:0] fbia_byte_t;
  typedef enum logic [2:0] {
    FBIA_IDLE = 3'b001,
    FBIA_RDAT = 3'b010,
    FBIA_WACK = 3'b100
  } fbia_bus_state_t;
endpackage : fbia_pkg

// >>> src/fbia_chan_if.sv
`timescale 1ns/1ps
interface fbia_chan_if;
  logic [7:0] status;
  logic [7:0] enable;
  logic [2:0] ctrl;
  logic rd_status;
  logic req;
  modport core (output status, output enable, output ctrl, output req, input rd_status);
  modport top (input status, input enable, input ctrl, input req, output rd_status);
endinterface : fbia_chan_if

// >>> src/fbia_channel.sv
`timescale 1ns/1ps
`include "fbia_regs.svh"
module fbia_channel
  import fbia_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host writes, already decoded for this channel
  input wire logic wr_en_i,
  input wire logic wr_ctrl_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_status_i,
  // source events and block pendings, synchronous
  input wire logic clkloss_evt_i,
  input wire logic one_second_tick_flag_evt_i,
  input wire logic [5:0] block_pend_i,
  // views
  fbia_chan_if.core ch
);
  fbia_byte_t en_q, en_d;
  logic [1:0] st_q, st_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [7:0] status_w;
  logic rd_clr_w, wc_clr_w;

  // event flags: set wins over clear
  assign rd_clr_w = ch.rd_status & ~ctrl_q[`FBIA_CTRL_WC];  // [RULE_04] [RULE_05] [RULE_14]
  assign wc_clr_w = wr_status_i & ctrl_q[`FBIA_CTRL_WC];
  assign st_d[1] = clkloss_evt_i | (st_q[1] & ~rd_clr_w & ~(wc_clr_w & ~wr_data_i[`FBIA_BIT_CLKLOSS]));  // [RULE_04]
  assign st_d[0] = one_second_tick_flag_evt_i | (st_q[0] & ~rd_clr_w & ~(wc_clr_w & ~wr_data_i[`FBIA_BIT_ONE_SECOND_TICK_FLAG]));  // [RULE_05]
  // pending bits pass straight through from the owning blocks
  assign status_w = {block_pend_i[5:4], st_q, block_pend_i[3:0]};  // [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_10]
  // auto-clear drops enables of reported bits after a status read
  assign en_d = wr_en_i ? wr_data_i :
    ((ch.rd_status & ctrl_q[`FBIA_CTRL_AUTOCLR]) ? (en_q & ~status_w) : en_q);  // [RULE_10]
  assign ctrl_d = wr_ctrl_i ? wr_data_i[2:0] : ctrl_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= `FBIA_RST_BYTE;
      st_q <= 2'h0;
      ctrl_q <= 3'h0;
    end else begin
      en_q <= en_d;
      st_q <= st_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign ch.status = status_w;
  assign ch.enable = en_q;
  assign ch.ctrl = ctrl_q;
  assign ch.req = ctrl_q[`FBIA_CTRL_IRQ_EN] & |(status_w & en_q);  // [RULE_11] [RULE_12] [RULE_13] [RULE_15]

  AST_REQ_NEEDS_CH_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    ch.req |-> ctrl_q[`FBIA_CTRL_IRQ_EN]) else $error("request without channel enable"); // [RULE_13]
  AST_CLKLOSS_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    clkloss_evt_i |=> st_q[1]) else $error("clock loss flag not set"); // [RULE_04]
  AST_ONE_SECOND_TICK_FLAG_RUR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ch.rd_status && !ctrl_q[`FBIA_CTRL_WC] && !one_second_tick_flag_evt_i) |=> !st_q[0])
    else $error("one second flag not cleared by read"); // [RULE_05]
  AST_ENABLE_PAIRS: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`FBIA_CTRL_IRQ_EN] && block_pend_i[3] && en_q[`FBIA_BIT_LINK]) |-> ch.req)
    else $error("enabled link request lost"); // [RULE_11]
  AST_DISABLE_BLOCKS: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_q == 8'h00) |-> !ch.req) else $error("disabled block raised request"); // [RULE_12]
endmodule : fbia_channel

// >>> src/fbia_top.sv
`timescale 1ns/1ps
`include "fbia_regs.svh"
// ---------------------------------------------------------------
// Overview of operation
// RULE_01 - irq output goes low while any enabled condition is active.
// RULE_02 - host reads block status of every enabled channel to find requester.
// RULE_03 - channel n status sits at address pair {n,A},02 for channels 0..7; the code decodes status at {n,0} and {n,2}.
// RULE_04 - bit 5 records recovered clock loss since last read; read clears it.
// RULE_05 - bit 4 records one-second tick since last read; read clears it.
// RULE_06 - bit 3 follows link controller pending; cleared by its status read.
// RULE_07 - bit 2 follows slip buffer pending; cleared by its status read.
// RULE_08 - bit 1 follows alarm/error pending; cleared by its status read.
// RULE_09 - bit 0 follows frame block pending, zero when none.
// RULE_10 - enable has rw bit per block; spare bit 7, loopback 6 read-only status.
// RULE_11 - enable bits use the same positions as status bits.
// RULE_12 - enable zero blocks that request; one allows it.
// RULE_13 - output needs channel, block and source enables together.
// RULE_14 - read-clear mode releases output on reading last active status.
// RULE_15 - channel request is OR of status and enable, gated by channel enable.
// ---------------------------------------------------------------
module fbia_top
  import fbia_pkg::*;
#(
  parameter int NUM_CH = `FBIA_NUM_CH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // per-channel events and source-level pendings (source side clears these)
  input wire logic [NUM_CH-1:0] clkloss_evt_i,
  input wire logic [NUM_CH-1:0] one_second_tick_flag_evt_i,
  input wire logic [NUM_CH-1:0] spare_bit_six_flag_i,
  input wire logic [NUM_CH-1:0] loopback_code_flag_i,
  input wire logic [NUM_CH-1:0] link_pending_i,
  input wire logic [NUM_CH-1:0] slip_pending_i,
  input wire logic [NUM_CH-1:0] alarm_pending_i,
  input wire logic [NUM_CH-1:0] frame_block_pending_i,
  // source status reads, one-cycle pulses so owners can clear their pendings
  output logic [NUM_CH-1:0] link_src_read_o,
  output logic [NUM_CH-1:0] slip_src_read_o,
  output logic [NUM_CH-1:0] alarm_src_read_o,
  // interrupt
  output logic irq_n_o
);
  logic [3:0] ch_w;
  logic [3:0] sub_w;
  logic ch_ok_w;
  logic [NUM_CH-1:0] req_w;
  logic [7:0] rd_mux_w;
  fbia_byte_t rdata_q;

  assign ch_w = addr_i[7:4];
  assign sub_w = addr_i[3:0];
  assign ch_ok_w = (ch_w < 4'(NUM_CH));

  function automatic logic hit(input logic [3:0] ch, input logic [3:0] sub,
                               input int unsigned n, input logic [3:0] ofs);
    hit = (ch == 4'(n)) && (sub == ofs);
  endfunction : hit

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  fbia_chan_if chif [NUM_CH] ();
  logic [7:0] st_arr [NUM_CH];
  logic [7:0] en_arr [NUM_CH];
  logic [2:0] ct_arr [NUM_CH];

  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    // both status aliases answer; read of either is a status read
    assign chif[n].rd_status = rd_i & (hit(ch_w, sub_w, n, `FBIA_OFS_STATUS)
      | hit(ch_w, sub_w, n, `FBIA_OFS_ALIAS));  // [RULE_03] [RULE_14]
    assign link_src_read_o[n] = rd_i & hit(ch_w, sub_w, n, `FBIA_OFS_LINK_SRC);  // [RULE_06]
    assign slip_src_read_o[n] = rd_i & hit(ch_w, sub_w, n, `FBIA_OFS_SLIP_SRC);  // [RULE_07]
    assign alarm_src_read_o[n] = rd_i & hit(ch_w, sub_w, n, `FBIA_OFS_ALARM_SRC);  // [RULE_08]
    assign req_w[n] = chif[n].req;
    assign st_arr[n] = chif[n].status;
    assign en_arr[n] = chif[n].enable;
    assign ct_arr[n] = chif[n].ctrl;
    fbia_channel fbia_channel_i (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_en_i(wr_i & hit(ch_w, sub_w, n, `FBIA_OFS_ENABLE)),
      .wr_ctrl_i(wr_i & hit(ch_w, sub_w, n, `FBIA_OFS_CTRL)),
      .wr_data_i(wdata_i),
      .wr_status_i(wr_i & hit(ch_w, sub_w, n, `FBIA_OFS_STATUS)),
      .clkloss_evt_i(clkloss_evt_i[n]),
      .one_second_tick_flag_evt_i(one_second_tick_flag_evt_i[n]),
      .block_pend_i({spare_bit_six_flag_i[n], loopback_code_flag_i[n], link_pending_i[n],
                     slip_pending_i[n], alarm_pending_i[n], frame_block_pending_i[n]}),
      .ch(chif[n].core)
    );
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux_w = 8'h00;
    if (ch_ok_w) begin
      case (sub_w)
        `FBIA_OFS_STATUS, `FBIA_OFS_ALIAS: rd_mux_w = st_arr[ch_w[2:0]];  // [RULE_03]
        `FBIA_OFS_ENABLE: rd_mux_w = en_arr[ch_w[2:0]];
        `FBIA_OFS_CTRL: rd_mux_w = {5'h00, ct_arr[ch_w[2:0]]};
        default: rd_mux_w = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= `FBIA_RST_BYTE;
    end else begin
      rdata_q <= rd_i ? rd_mux_w : 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // ---------------------------------------------------------------
  // interrupt output, combinational so a clearing read releases it at once
  // ---------------------------------------------------------------
  assign irq_n_o = ~|req_w;  // [RULE_01] [RULE_15]

  AST_IRQ_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_w != '0) |-> !irq_n_o) else $error("irq not asserted"); // [RULE_01]
  AST_IRQ_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_w == '0) |-> irq_n_o) else $error("irq asserted without request"); // [RULE_15]
  AST_RDATA_STATUS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && addr_i == 8'h0a) |=> rdata_o == $past(st_arr[0]))
    else $error("status read data wrong"); // [RULE_03]
  // read data must not linger past its one answer cycle
  AST_RDATA_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 8'h00) else $error("read data not cleared"); // [RULE_03]
  AST_OUT_OF_RANGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && !ch_ok_w) |=> rdata_o == 8'h00) else $error("unmapped channel read nonzero"); // [RULE_03]
  AST_LINK_SRC_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (link_src_read_o != '0) |-> rd_i) else $error("link source read without host read"); // [RULE_06]
endmodule : fbia_top

// >>> bench/fbia_src_model.sv
`timescale 1ns/1ps
// ---
// source blocks: a pending holds until its own status is read
// ---
module fbia_src_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // set pulses and read pulses, {link, slip, alarm}
  input wire logic [23:0] set_i,
  input wire logic [23:0] clr_i,
  output logic [23:0] pend_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_o <= 24'h000000;
    end else begin
      pend_o <= (pend_o | set_i) & ~clr_i;
    end
  end
endmodule : fbia_src_model

// >>> bench/tb_fbia_top.sv
`timescale 1ns/1ps
module tb_fbia_top;
  import fbia_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, irq_n;
  logic [7:0] ck = 8'h00, os = 8'h00, sp = 8'h00, lb = 8'h00, fr = 8'h00;
  logic [23:0] src_set = 24'h000000, pend;
  wire [23:0] src_rd;
  int num_errors = 0;
  int checks = 0;
  initial forever #50 sys_clk_i = ~sys_clk_i;
  fbia_top fbia_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .clkloss_evt_i(ck), .one_second_tick_flag_evt_i(os),
    .spare_bit_six_flag_i(sp), .loopback_code_flag_i(lb), .link_pending_i(pend[23:16]),
    .slip_pending_i(pend[15:8]), .alarm_pending_i(pend[7:0]), .frame_block_pending_i(fr),
    .link_src_read_o(src_rd[23:16]), .slip_src_read_o(src_rd[15:8]),
    .alarm_src_read_o(src_rd[7:0]), .irq_n_o(irq_n));
  fbia_src_model fbia_src_model_i (.clk_i(sys_clk_i), .rst_i(rst_i), .set_i(src_set),
    .clr_i(src_rd), .pend_o(pend));
  // ---
  // bus and compare helpers
  // ---
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata, exp);
  endtask : rchk
  task automatic ichk(input logic exp);
    #1 chk("irq_n", {7'h00, irq_n}, {7'h00, exp});
  endtask : ichk
  task automatic pulse(input logic [7:0] c, input logic [7:0] o, input logic [23:0] s);
    @(posedge sys_clk_i);
    ck <= c;
    os <= o;
    src_set <= s;
    @(posedge sys_clk_i);
    ck <= 8'h00;
    os <= 8'h00;
    src_set <= 24'h000000;
  endtask : pulse
  task automatic stop_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // ---
  // scenarios
  // ---
  task automatic t_sticky;
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'(i * 16 + 3), 8'h01);
      wr_reg(8'(i * 16 + 1), 8'h30);
      pulse(8'h01 << i, 8'h00, 24'h000000);
      ichk(1'b0);
      rchk(8'(i * 16 + 2), 8'h20);
      ichk(1'b1);
      pulse(8'h00, 8'h01 << i, 24'h000000);
      rchk(8'(i * 16), 8'h10);
      rchk(8'(i * 16), 8'h00);
    end
    $display("t_sticky done");
  endtask : t_sticky
  task automatic t_levels;
    logic [7:0] subs [3] = '{8'h16, 8'h19, 8'h14};
    wr_reg(8'h13, 8'h01);
    wr_reg(8'h11, 8'h0f);
    for (int k = 0; k < 3; k++) begin
      pulse(8'h00, 8'h00, 24'h000002 << (8 * (2 - k)));
      ichk(1'b0);
      rchk(8'h10, 8'h08 >> k);
      rchk(8'h10, 8'h08 >> k);
      rchk(subs[k], 8'h00);
      rchk(8'h10, 8'h00);
      ichk(1'b1);
    end
    @(posedge sys_clk_i);
    fr <= 8'h02;
    rchk(8'h10, 8'h01);
    ichk(1'b0);
    @(posedge sys_clk_i);
    fr <= 8'h00;
    rchk(8'h10, 8'h00);
    $display("t_levels done");
  endtask : t_levels
  // host scans every enabled channel after irq goes low
  task automatic t_scan;
    pulse(8'h44, 8'h00, 24'h000000);
    ichk(1'b0);
    for (int n = 0; n < 8; n++) begin
      rchk(8'(n * 16 + 2), (n == 2 || n == 6) ? 8'h20 : 8'h00);
      if (n == 2) ichk(1'b0);
    end
    ichk(1'b1);
    $display("t_scan done");
  endtask : t_scan
  // write-to-clear mode, then enable auto-clear, on channel 5
  task automatic t_modes;
    wr_reg(8'h53, 8'h05);
    pulse(8'h20, 8'h20, 24'h000000);
    rchk(8'h50, 8'h30);
    ichk(1'b0);
    wr_reg(8'h50, 8'h10);
    rchk(8'h50, 8'h10);
    wr_reg(8'h50, 8'h00);
    rchk(8'h50, 8'h00);
    ichk(1'b1);
    wr_reg(8'h53, 8'h03);
    pulse(8'h20, 8'h00, 24'h000000);
    ichk(1'b0);
    rchk(8'h50, 8'h20);
    rchk(8'h51, 8'h10);
    ichk(1'b1);
    wr_reg(8'h51, 8'h30);
    wr_reg(8'h53, 8'h01);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_mask;
    wr_reg(8'h33, 8'h01);
    fr <= 8'h08;
    rchk(8'h30, 8'h01);
    ichk(1'b1);
    wr_reg(8'h31, 8'h01);
    ichk(1'b0);
    wr_reg(8'h33, 8'h00);
    ichk(1'b1);
    @(posedge sys_clk_i);
    fr <= 8'h00;
    sp <= 8'h08;
    lb <= 8'h08;
    wr_reg(8'h31, 8'hc0);
    wr_reg(8'h33, 8'h01);
    rchk(8'h30, 8'hc0);
    ichk(1'b0);
    rchk(8'h31, 8'hc0);
    rchk(8'h80, 8'h00);
    $display("t_mask done");
  endtask : t_mask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rchk(8'h0a, 8'h00);
    rchk(8'h01, 8'h00);
    ichk(1'b1);
    t_sticky();
    t_levels();
    t_scan();
    t_modes();
    t_mask();
    stop_test();
  end
  // hang guard: the whole run needs far fewer cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    stop_test();
  end
endmodule : tb_fbia_top
